/* src/pmc_top.sv */
// power mode controller: supervisors, regulator mode, low-power sequencing, clock fallback
// Notes on behaviour
// R1 - hold all logic in reset while the monitored supply is under threshold
// R2 - power-on release looks only at the main supply
// R3 - power-down watches both supplies; option bit drops the analog part
// R4 - enabled level detector flags falling, rising or both crossings
// R5 - regulator enabled after any reset, main or low-power mode
// R6 - regulator in main mode while running
// R7 - in stop the regulator mode follows software choice
// R8 - in standby the regulator is off and core domain is lost
// R9 - sleep stops only the processor clock; any peripheral interrupt wakes it
// R10 - stop halts core clocks and disables pll, fast rc and crystal
// R11 - stop keeps sram and register contents
// R12 - any extended event line leaves stop
// R13 - two-wire and serial ports may request the fast rc during stop
// R14 - such a request first returns the regulator to main mode
// R15 - standby drops all state except rtc domain and standby logic
// R16 - standby exits on reset pin, watchdog reset, wake pin rise, rtc event
// R17 - rtc, watchdog and their clocks never stop
// R18 - after reset the fast internal rc clocks the processor
// R19 - failed crystal falls back to the rc and flags an interrupt
// R20 - software selects stop or standby before the sleep request
// R21 - standby wake acts as reset; stop wake resumes on the rc
module pmc_top #(
  parameter int FAIL_CYC = pmc_pkg::PMC_CLK_FAIL_CYC
) (
  input  wire logic                               mclk,
  input  wire logic                               rst_n,
  input  wire pmc_pkg::pmc_supply_t               supply,
  input  wire logic                               analog_supervisor_off,
  input  wire logic                               detector_en,
  input  wire logic [1:0]                         detector_edge_sel,
  input  wire logic                               sleep_request,
  input  wire logic                               deep_sleep_sel,
  input  wire logic                               standby_sel,
  input  wire logic                               stop_low_power_sel,
  input  wire logic                               peripheral_irq,
  input  wire logic [pmc_pkg::PMC_EXT_LINES-1:0]  extended_event_lines,
  input  wire logic                               rtc_event,
  input  wire logic                               two_wire_port_wake,
  input  wire logic                               serial_port_wake,
  input  wire logic                               two_wire_port_clk_req,
  input  wire logic                               serial_port_clk_req,
  input  wire logic                               external_reset_pin_n,
  input  wire logic                               independent_watchdog_reset,
  input  wire logic                               wake_pin,
  input  wire pmc_pkg::pmc_src_t                  clk_src_sel,
  input  wire logic                               crystal_toggle,
  input  wire logic                               clk_fail_irq_en,
  input  wire logic                               clk_fail_clear,
  output logic                                    core_reset_n,
  output logic                                    detector_irq,
  output logic                                    detector_level,
  output logic                                    regulator_on,
  output logic                                    regulator_main_mode,
  output logic                                    regulator_low_power_mode,
  output pmc_pkg::pmc_clk_t                       clk_ctl,
  output pmc_pkg::pmc_src_t                       cpu_clk_src,
  output logic                                    clk_fail_flag,
  output logic                                    clk_fail_irq,
  output pmc_pkg::pmc_state_t                     power_state
);
  localparam int NS = 3 + 2 + 16 + 5;

  // every pin-level input crosses two flops first
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn_in;
  assign raw_in = {supply, external_reset_pin_n, independent_watchdog_reset,
                   extended_event_lines, rtc_event, two_wire_port_wake,
                   serial_port_wake, wake_pin, crystal_toggle};

  pmc_sync #(.WIDTH(NS)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .sync_out (syn_in)
  );

  pmc_pkg::pmc_supply_t                    s_supply;
  logic                                    s_pin_n;
  logic                                    s_wdg;
  logic [pmc_pkg::PMC_EXT_LINES-1:0]       s_ext;
  logic                                    s_rtc;
  logic                                    s_twp;
  logic                                    s_ser;
  logic                                    s_wake;
  logic                                    s_xtal;
  assign {s_supply, s_pin_n, s_wdg, s_ext, s_rtc, s_twp, s_ser, s_wake, s_xtal} = syn_in;

  // supervisor: power-on watches main only, power-down also the analog supply
  logic supply_good;
  logic powered;
  logic next_powered;
  logic wake_pin_q;
  logic next_wake_pin_q;
  logic standby_exit;
  pmc_pkg::pmc_state_t state;
  pmc_pkg::pmc_state_t next_state;
  logic [2:0] hold_cnt;
  logic [2:0] next_hold_cnt;

  always_comb begin
    supply_good = s_supply.main_supply_ok &
                  (s_supply.analog_supply_ok | analog_supervisor_off); // [R3]
    // once released, only a power-down drop re-asserts; release needs main only
    next_powered = powered ? supply_good : s_supply.main_supply_ok; // [R2]
    next_wake_pin_q = s_wake;
    standby_exit = !s_pin_n | s_wdg | (s_wake & !wake_pin_q) | s_rtc; // [R16]
    next_hold_cnt = hold_cnt;
    if (!powered || (state == pmc_pkg::PMC_STANDBY && standby_exit)) begin
      next_hold_cnt = 3'(pmc_pkg::PMC_RESET_HOLD_CYC); // [R21]
    end else if (hold_cnt != 3'h0) begin
      next_hold_cnt = hold_cnt - 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      powered    <= 1'b0;
      wake_pin_q <= 1'b0;
      hold_cnt   <= 3'h1;
    end else begin
      powered    <= next_powered;
      wake_pin_q <= next_wake_pin_q;
      hold_cnt   <= next_hold_cnt;
    end
  end

  // core reset held while unpowered, in standby, or stretching after either
  assign core_reset_n = powered && hold_cnt == 3'h0 &&
                        state != pmc_pkg::PMC_STANDBY; // [R1] [R15]

  // level detector with edge-selectable interrupt
  logic det_q;
  logic next_det_q;
  logic next_detector_irq;
  always_comb begin
    next_det_q        = s_supply.main_above_threshold;
    next_detector_irq = 1'b0;
    if (detector_en) begin // [R4]
      if ((detector_edge_sel & pmc_pkg::PMC_DET_FALL) != 2'h0 && det_q && !next_det_q) begin
        next_detector_irq = 1'b1;
      end
      if ((detector_edge_sel & pmc_pkg::PMC_DET_RISE) != 2'h0 && !det_q && next_det_q) begin
        next_detector_irq = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      det_q        <= 1'b0;
      detector_irq <= 1'b0;
    end else begin
      det_q        <= next_det_q;
      detector_irq <= next_detector_irq;
    end
  end
  assign detector_level = detector_en & det_q;

  // low-power sequencer
  logic stop_wake;
  logic clk_req;
  logic [3:0] settle;
  logic [3:0] next_settle;
  logic next_reg_lp;
  logic reg_lp;
  always_comb begin
    stop_wake = (|s_ext) | detector_irq | s_rtc | s_twp | s_ser; // [R12]
    clk_req   = two_wire_port_clk_req | serial_port_clk_req;
    next_state  = state;
    next_reg_lp = 1'b0; // [R6]
    next_settle = settle;
    case (state)
      pmc_pkg::PMC_RUN: begin
        if (sleep_request) begin // [R20]
          if (!deep_sleep_sel) begin
            next_state = pmc_pkg::PMC_SLEEP;
          end else if (standby_sel) begin
            next_state = pmc_pkg::PMC_STANDBY; // [R8]
          end else begin
            next_state  = pmc_pkg::PMC_STOP;
            next_reg_lp = stop_low_power_sel; // [R7]
          end
        end
      end
      pmc_pkg::PMC_SLEEP: begin
        if (peripheral_irq || stop_wake) begin
          next_state = pmc_pkg::PMC_RUN; // [R9]
        end
      end
      pmc_pkg::PMC_STOP: begin
        // any exit puts the regulator back in main mode no later than the rc restarts
        if (stop_wake) begin
          next_state = pmc_pkg::PMC_WAKE; // [R11]
        end else if (clk_req) begin
          next_reg_lp = 1'b0; // [R14]
          next_settle = 4'(pmc_pkg::PMC_REG_SETTLE_CYC);
          next_state  = pmc_pkg::PMC_STOP_REG;
        end else begin
          next_reg_lp = reg_lp; // [R7]
        end
      end
      pmc_pkg::PMC_STOP_REG: begin
        // regulator is back in main mode; rc runs once settled
        if (settle != 4'h0) begin
          next_settle = settle - 4'h1;
        end
        if (stop_wake) begin
          next_state = pmc_pkg::PMC_WAKE;
        end else if (!clk_req && settle == 4'h0) begin
          next_state  = pmc_pkg::PMC_STOP;
          next_reg_lp = stop_low_power_sel;
        end
      end
      pmc_pkg::PMC_STANDBY: begin
        if (standby_exit) begin
          next_state = pmc_pkg::PMC_RUN; // [R16] [R21]
        end
      end
      pmc_pkg::PMC_WAKE: begin
        next_state = pmc_pkg::PMC_RUN;
      end
      default: begin
        next_state = pmc_pkg::PMC_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= pmc_pkg::PMC_RUN;
      reg_lp <= 1'b0; // [R5]
      settle <= 4'h0;
    end else begin
      state  <= next_state;
      reg_lp <= next_reg_lp;
      settle <= next_settle;
    end
  end

  assign power_state              = state;
  assign regulator_on             = state != pmc_pkg::PMC_STANDBY; // [R5] [R8]
  assign regulator_low_power_mode = regulator_on & reg_lp;
  assign regulator_main_mode      = regulator_on & !reg_lp;

  // clock source: rc after reset, forced back on crystal failure
  logic xtal_failed;
  pmc_clk_mon #(.FAIL_CYC(FAIL_CYC)) u_mon (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .enable         (cpu_clk_src == pmc_pkg::PMC_SRC_CRYSTAL),
    .crystal_toggle (s_xtal),
    .failed         (xtal_failed)
  );

  pmc_pkg::pmc_src_t next_src;
  logic              next_fail_flag;
  logic              src_stuck;
  logic              next_src_stuck;
  always_comb begin
    next_src       = clk_src_sel;
    next_src_stuck = src_stuck & (clk_src_sel != pmc_pkg::PMC_SRC_FAST_RC);
    // standby and stop resume on the rc
    if (state == pmc_pkg::PMC_STANDBY || state == pmc_pkg::PMC_WAKE ||
        src_stuck || xtal_failed) begin
      next_src = pmc_pkg::PMC_SRC_FAST_RC; // [R18] [R19] [R21]
    end
    // after a wake the selection must go back to the rc before an old source is taken again
    if (xtal_failed || state == pmc_pkg::PMC_WAKE || state == pmc_pkg::PMC_STANDBY) begin
      next_src_stuck = 1'b1; // [R21]
    end
    // set wins over clear
    next_fail_flag = xtal_failed | (clk_fail_flag & !clk_fail_clear); // [R19]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_src   <= pmc_pkg::PMC_SRC_FAST_RC; // [R18]
      clk_fail_flag <= 1'b0;
      src_stuck     <= 1'b0;
    end else begin
      cpu_clk_src   <= next_src;
      clk_fail_flag <= next_fail_flag;
      src_stuck     <= next_src_stuck;
    end
  end
  assign clk_fail_irq = clk_fail_flag & clk_fail_irq_en;

  // clock enables per state
  logic deep;
  assign deep = state == pmc_pkg::PMC_STOP || state == pmc_pkg::PMC_STOP_REG ||
                state == pmc_pkg::PMC_STANDBY;
  always_comb begin
    clk_ctl.cpu_clk_en  = state == pmc_pkg::PMC_RUN; // [R9]
    clk_ctl.core_clk_en = !deep; // [R10]
    clk_ctl.pll_en      = !deep && cpu_clk_src == pmc_pkg::PMC_SRC_PLL;
    clk_ctl.internal_fast_oscillator_en = !deep ||
      (state == pmc_pkg::PMC_STOP_REG && settle == 4'h0); // [R13] [R14]
    clk_ctl.external_crystal_oscillator_en = !deep &&
      cpu_clk_src != pmc_pkg::PMC_SRC_FAST_RC; // [R10]
    clk_ctl.rtc_clk_en      = 1'b1; // [R17]
    clk_ctl.watchdog_clk_en = 1'b1; // [R17]
  end

  a_stop_gates: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
    state == pmc_pkg::PMC_STOP |-> !clk_ctl.core_clk_en && !clk_ctl.pll_en &&
    !clk_ctl.internal_fast_oscillator_en) else $error("stop clocks running");
  a_rc_needs_main: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
    clk_ctl.internal_fast_oscillator_en |-> !regulator_low_power_mode)
    else $error("rc on with low power regulator");
  a_standby_off: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    state == pmc_pkg::PMC_STANDBY |-> !regulator_on && !core_reset_n)
    else $error("standby regulator on");
  a_run_main_mode: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
    state == pmc_pkg::PMC_RUN |-> regulator_main_mode) else $error("run not main");
  a_fail_fallback: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
    xtal_failed |=> cpu_clk_src == pmc_pkg::PMC_SRC_FAST_RC && clk_fail_flag)
    else $error("no fallback");
  a_stop_wake_exit: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
    state == pmc_pkg::PMC_STOP && stop_wake |=> state == pmc_pkg::PMC_WAKE ##1
    state == pmc_pkg::PMC_RUN) else $error("stop wake missed");
  a_sleep_cpu_only: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
    state == pmc_pkg::PMC_SLEEP |-> !clk_ctl.cpu_clk_en && clk_ctl.core_clk_en)
    else $error("sleep gating wrong");
  a_unpowered_reset: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    !s_supply.main_supply_ok |-> ##2 !core_reset_n) else $error("reset not held");
  a_det_fall_irq: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    detector_en && detector_edge_sel == 2'h1 && $fell(next_det_q) |=> detector_irq)
    else $error("detector irq missed");
endmodule : pmc_top

/* src/pmc_pkg.sv */
// package: shared constants and types for the power mode controller
package pmc_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    PMC_RUN      = 3'b000,
    PMC_SLEEP    = 3'b001,
    PMC_STOP     = 3'b010,
    PMC_STOP_REG = 3'b011,
    PMC_STANDBY  = 3'b100,
    PMC_WAKE     = 3'b101
  } pmc_state_t;

  // processor clock sources
  typedef enum logic [1:0] {
    PMC_SRC_FAST_RC = 2'b00,
    PMC_SRC_CRYSTAL = 2'b01,
    PMC_SRC_PLL     = 2'b10
  } pmc_src_t;

  // raw supply supervisor indications, all asynchronous to mclk
  typedef struct packed {
    logic main_supply_ok;
    logic analog_supply_ok;
    logic main_above_threshold;
  } pmc_supply_t;

  // clock gate and oscillator enables driven to the clock tree
  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic pll_en;
    logic internal_fast_oscillator_en;
    logic external_crystal_oscillator_en;
    logic rtc_clk_en;
    logic watchdog_clk_en;
  } pmc_clk_t;

  localparam int         PMC_EXT_LINES    = 16;
  localparam int         PMC_MCLK_MHZ     = 250;
  localparam int         PMC_RESET_HOLD_NS = 20;
  localparam int         PMC_RESET_HOLD_CYC =
    (PMC_RESET_HOLD_NS * PMC_MCLK_MHZ + 999) / 1000;
  localparam int         PMC_REG_SETTLE_NS = 40;
  localparam int         PMC_REG_SETTLE_CYC =
    (PMC_REG_SETTLE_NS * PMC_MCLK_MHZ + 999) / 1000;
  localparam int         PMC_CLK_FAIL_NS  = 1000;
  localparam int         PMC_CLK_FAIL_CYC = (PMC_CLK_FAIL_NS * PMC_MCLK_MHZ) / 1000;
  localparam logic [1:0] PMC_DET_FALL     = 2'h0_1;
  localparam logic [1:0] PMC_DET_RISE     = 2'h0_2;

endpackage : pmc_pkg

/* src/pmc_sync.sv */
// two-flop synchroniser for a bus of asynchronous levels
module pmc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // stage1 feeds only sync_out
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : pmc_sync

/* src/pmc_clk_mon.sv */
// external clock monitor: flags a crystal that stops toggling
module pmc_clk_mon #(
  parameter int FAIL_CYC = 250
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic crystal_toggle,
  output logic      failed
);
  localparam int CW = $clog2(FAIL_CYC + 1);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          last;
  logic          next_last;
  logic          next_failed;

  // count mclk cycles since the last toggle seen on the crystal divider bit
  always_comb begin
    next_last   = crystal_toggle;
    next_count  = count;
    next_failed = failed;
    if (!enable) begin
      next_count  = '0;
      next_failed = 1'b0;
    end else if (crystal_toggle != last) begin
      next_count = '0;
    end else if (count == CW'(FAIL_CYC)) begin
      next_failed = 1'b1;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count  <= '0;
      last   <= 1'b0;
      failed <= 1'b0;
    end else begin
      count  <= next_count;
      last   <= next_last;
      failed <= next_failed;
    end
  end
endmodule : pmc_clk_mon

/* verif/pmc_far_model.sv */
// far side model: wake and reset sources plus a divided crystal
module pmc_far_model (
  input  wire logic   mclk,
  input  wire logic   crystal_en,
  input  wire logic   crystal_run,
  output logic        crystal_toggle,
  output logic [15:0] extended_event_lines,
  output logic        rtc_event,
  output logic        two_wire_port_wake,
  output logic        serial_port_wake,
  output logic        wake_pin,
  output logic        independent_watchdog_reset,
  output logic        external_reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] src;

  initial begin
    src = '0;
    crystal_toggle = 1'b0;
  end

  // a crystal toggles only while powered; crystal_run low models a broken part
  always @(posedge mclk) begin
    if (crystal_en === 1'b1 && crystal_run === 1'b1) begin
      crystal_toggle <= ~crystal_toggle;
    end
  end

  // source map: 0 line 0, 1 line 15, 2 rtc, 3 two-wire, 4 serial, 5 pin, 6 watchdog, 7 reset
  assign extended_event_lines       = {src[1], 14'h0, src[0]};
  assign rtc_event                  = src[2];
  assign two_wire_port_wake         = src[3];
  assign serial_port_wake           = src[4];
  assign wake_pin                   = src[5];
  assign independent_watchdog_reset = src[6];
  assign external_reset_pin_n       = ~src[7];

  // held four cycles so the two-flop synchroniser surely sees it
  task automatic pulse_src(input int k);
    @(posedge mclk);
    src[k] <= 1'b1;
    repeat (4) @(posedge mclk);
    src[k] <= 1'b0;
  endtask : pulse_src
endmodule : pmc_far_model

/* verif/tb_pmc_top.sv */
// self-checking testbench for the power mode controller
module tb_pmc_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FAIL  = 8;
  localparam int LIMIT = 6000;
  logic mclk, rst_n, analog_supervisor_off, detector_en, sleep_request, deep_sleep_sel;
  logic standby_sel, stop_low_power_sel, peripheral_irq, rtc_event, two_wire_port_wake;
  logic serial_port_wake, wake_pin, two_wire_port_clk_req, serial_port_clk_req;
  logic external_reset_pin_n, independent_watchdog_reset, crystal_toggle, clk_fail_irq_en;
  logic clk_fail_clear, core_reset_n, detector_irq, detector_level, regulator_on;
  logic regulator_main_mode, regulator_low_power_mode, clk_fail_flag, clk_fail_irq;
  logic crystal_run, seen_rst_low;
  logic [1:0]           detector_edge_sel;
  logic [15:0]          extended_event_lines;
  pmc_pkg::pmc_supply_t supply;
  pmc_pkg::pmc_src_t    clk_src_sel, cpu_clk_src;
  pmc_pkg::pmc_clk_t    clk_ctl;
  pmc_pkg::pmc_state_t  power_state;
  int                   num_errors, cmp_count, cycles, irq_count;
  int                   sb_src[4] = '{5, 6, 7, 2};

  pmc_top #(.FAIL_CYC(FAIL)) pmc_top_i (
    .mclk, .rst_n, .supply, .analog_supervisor_off, .detector_en, .detector_edge_sel,
    .sleep_request, .deep_sleep_sel, .standby_sel, .stop_low_power_sel, .peripheral_irq,
    .extended_event_lines, .rtc_event, .two_wire_port_wake, .serial_port_wake,
    .two_wire_port_clk_req, .serial_port_clk_req, .external_reset_pin_n,
    .independent_watchdog_reset, .wake_pin, .clk_src_sel, .crystal_toggle,
    .clk_fail_irq_en, .clk_fail_clear, .core_reset_n, .detector_irq, .detector_level,
    .regulator_on, .regulator_main_mode, .regulator_low_power_mode, .clk_ctl, .cpu_clk_src,
    .clk_fail_flag, .clk_fail_irq, .power_state);

  pmc_far_model pmc_far_model_i (
    .mclk, .crystal_en(clk_ctl.external_crystal_oscillator_en), .crystal_run,
    .crystal_toggle, .extended_event_lines, .rtc_event, .two_wire_port_wake,
    .serial_port_wake, .wake_pin, .independent_watchdog_reset, .external_reset_pin_n);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // run-length guard, detector pulse counter and sticky reset sighting
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (detector_irq === 1'b1) irq_count <= irq_count + 1;
    if (core_reset_n === 1'b0) seen_rst_low <= 1'b1;
    if (cycles == LIMIT) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic wait_state(input pmc_pkg::pmc_state_t s, input int lim);
    for (int i = 0; i < lim && power_state !== s; i++) @(posedge mclk);
  endtask : wait_state

  task automatic wait_rst(input logic v, input int lim);
    for (int i = 0; i < lim && core_reset_n !== v; i++) @(posedge mclk);
  endtask : wait_rst

  // selects settle a cycle before the one-cycle sleep request
  task automatic go_low(input logic deep, input logic stby, input logic lp);
    @(posedge mclk);
    deep_sleep_sel <= deep;
    standby_sel <= stby;
    stop_low_power_sel <= lp;
    @(posedge mclk);
    sleep_request <= 1'b1;
    @(posedge mclk);
    sleep_request <= 1'b0;
  endtask : go_low

  initial begin
    {rst_n, analog_supervisor_off, detector_en, sleep_request, deep_sleep_sel} = '0;
    {standby_sel, stop_low_power_sel, peripheral_irq, two_wire_port_clk_req} = '0;
    {serial_port_clk_req, clk_fail_irq_en, clk_fail_clear, crystal_run} = '0;
    {num_errors, cmp_count, cycles, irq_count, seen_rst_low} = '0;
    detector_edge_sel = 2'h0;
    supply = 3'h7;
    clk_src_sel = pmc_pkg::PMC_SRC_FAST_RC;
    tick(20);
    rst_n <= 1'b1;
    wait_rst(1'b1, 40);
    chk("core_reset_n", core_reset_n, 1);
    chk("cpu_clk_src", cpu_clk_src, pmc_pkg::PMC_SRC_FAST_RC);
    chk("regulator_on", regulator_on, 1);
    chk("regulator_main", regulator_main_mode, 1);
    // supervisors: main drop, analog drop, analog drop with its watch switched off
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      analog_supervisor_off <= (i == 2);
      supply.main_supply_ok <= (i != 0);
      supply.analog_supply_ok <= (i == 0);
      tick(8);
      chk("held_reset", core_reset_n, (i == 2));
      if (i == 2) begin
        @(posedge mclk) supply.main_supply_ok <= 1'b0;
        tick(8);
        @(posedge mclk) supply.main_supply_ok <= 1'b1;
        wait_rst(1'b1, 40);
        chk("main_only_release", core_reset_n, 1);
      end
      @(posedge mclk) supply <= 3'h7;
      wait_rst(1'b1, 40);
    end
    // level detector: disabled, falling only, rising only, both
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      detector_en <= (i != 0);
      detector_edge_sel <= (i == 0) ? 2'h3 : i[1:0];
      tick(6);
      #1 irq_count = 0;
      @(posedge mclk) supply.main_above_threshold <= 1'b0;
      tick(10);
      @(posedge mclk) supply.main_above_threshold <= 1'b1;
      tick(10);
      chk("detector_pulses", irq_count, (i == 0) ? 0 : i[0] + i[1]);
      chk("detector_level", detector_level, i != 0);
    end
    // sleep keeps peripherals clocked and wakes on their interrupt
    go_low(1'b0, 1'b0, 1'b0);
    wait_state(pmc_pkg::PMC_SLEEP, 10);
    chk("sleep_state", power_state, pmc_pkg::PMC_SLEEP);
    chk("sleep_clks", {clk_ctl.cpu_clk_en, clk_ctl.core_clk_en}, 1);
    @(posedge mclk) peripheral_irq <= 1'b1;
    wait_state(pmc_pkg::PMC_RUN, 10);
    @(posedge mclk) peripheral_irq <= 1'b0;
    chk("sleep_wake", power_state, pmc_pkg::PMC_RUN);
    // stop with each wake source but the detector; two of them request the fast rc in low-power mode
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk) clk_src_sel <= (k == 2) ? pmc_pkg::PMC_SRC_PLL : pmc_pkg::PMC_SRC_FAST_RC;
      go_low(1'b1, 1'b0, k[0]);
      wait_state(pmc_pkg::PMC_STOP, 10);
      chk("stop_state", power_state, pmc_pkg::PMC_STOP);
      chk("stop_lp", regulator_low_power_mode, k[0]);
      chk("stop_clks", {clk_ctl.core_clk_en, clk_ctl.pll_en, clk_ctl.internal_fast_oscillator_en,
          clk_ctl.external_crystal_oscillator_en}, 0);
      chk("stop_keep", {clk_ctl.rtc_clk_en, clk_ctl.watchdog_clk_en}, 3);
      chk("stop_reg_on", regulator_on, 1);
      if (k[0]) begin
        @(posedge mclk);
        serial_port_clk_req <= (k == 1);
        two_wire_port_clk_req <= (k == 3);
        repeat (14) begin
          @(posedge mclk);
          if (clk_ctl.internal_fast_oscillator_en === 1'b1)
            chk("main_first", regulator_main_mode, 1);
        end
        chk("fast_rc_on", clk_ctl.internal_fast_oscillator_en, 1);
      end
      pmc_far_model_i.pulse_src(k);
      wait_state(pmc_pkg::PMC_RUN, 30);
      chk("stop_wake", power_state, pmc_pkg::PMC_RUN);
      tick(2);
      chk("stop_wake_src", cpu_clk_src, pmc_pkg::PMC_SRC_FAST_RC);
      @(posedge mclk);
      serial_port_clk_req <= 1'b0;
      two_wire_port_clk_req <= 1'b0;
      clk_src_sel <= pmc_pkg::PMC_SRC_FAST_RC;
    end
    // standby with each of its exit sources; state is lost, so a reset must follow
    for (int k = 0; k < 4; k++) begin
      #1 seen_rst_low = 1'b0;
      go_low(1'b1, 1'b1, 1'b0);
      wait_state(pmc_pkg::PMC_STANDBY, 10);
      chk("standby_reg", regulator_on, 0);
      chk("standby_keep", {clk_ctl.rtc_clk_en, clk_ctl.watchdog_clk_en}, 3);
      pmc_far_model_i.pulse_src(sb_src[k]);
      wait_state(pmc_pkg::PMC_RUN, 40);
      wait_rst(1'b1, 40);
      chk("standby_exit", power_state, pmc_pkg::PMC_RUN);
      chk("standby_reset", seen_rst_low, 1);
      chk("standby_src", cpu_clk_src, pmc_pkg::PMC_SRC_FAST_RC);
    end
    // crystal selected, then broken: fall back to rc with a sticky flag
    @(posedge mclk);
    crystal_run <= 1'b1;
    clk_fail_irq_en <= 1'b1;
    clk_src_sel <= pmc_pkg::PMC_SRC_CRYSTAL;
    tick(40);
    chk("src_crystal", cpu_clk_src, pmc_pkg::PMC_SRC_CRYSTAL);
    @(posedge mclk) crystal_run <= 1'b0;
    tick(FAIL + 20);
    chk("fallback_src", cpu_clk_src, pmc_pkg::PMC_SRC_FAST_RC);
    chk("fail_flag_irq", {clk_fail_flag, clk_fail_irq}, 3);
    @(posedge mclk) clk_src_sel <= pmc_pkg::PMC_SRC_FAST_RC;
    @(posedge mclk) clk_fail_clear <= 1'b1;
    @(posedge mclk) clk_fail_clear <= 1'b0;
    tick(2);
    chk("fail_cleared", {clk_fail_flag, clk_fail_irq}, 0);
    end_sim();
  end
endmodule : tb_pmc_top
